/* File: link_config_command_handler.sv */
// link_config_command_handler.sv: decodes the link configuration command,
// checks forced settings, drives the link request and answers the controller.
// Assumes the header, checksum check and identifier match happen upstream;
// the command code is held steady on cmd_code_in while the frame arrives.
`default_nettype none
module link_config_command_handler
	import link_cfg_pkg::*;
(
	// clock and reset
	input  wire logic                core_clk_in,
	input  wire logic                rst_in,
	// command frame byte stream
	input  wire logic                rx_valid_in,
	input  wire logic [7:0]          rx_byte_in,
	input  wire logic                rx_last_in,
	input  wire logic [7:0]          cmd_code_in,
	// port capabilities
	input  link_cfg_pkg::speed_t     speed_supported_in,
	input  link_cfg_pkg::duplex_t    duplex_supported_in,
	// checksum for the response, from the checksum engine
	input  link_cfg_pkg::word_t      rsp_csum_in,
	// response byte stream
	input  wire logic                tx_ready_in,
	output logic                     tx_valid_out,
	output logic [7:0]               tx_byte_out,
	output link_cfg_pkg::bidx_t      tx_idx_out,
	output logic                     tx_last_out,
	// link configuration towards the phy manager
	output logic                     link_apply_out,
	output logic                     link_autoneg_out,
	output link_cfg_pkg::speed_t     link_speed_out,
	output link_cfg_pkg::duplex_t    link_duplex_out,
	output logic                     link_pause_sym_out,
	output logic                     link_pause_asym_out,
	output logic                     vendor_apply_out,
	output link_cfg_pkg::word_t      vendor_word_out,
	// status
	output logic                     busy_out,
	output logic                     cmd_dropped_out,
	output logic [15:0]              last_code_out,
	output logic [15:0]              last_reason_out
);
	// ------------------------------------------------------------------
	// command frame capture
	// ------------------------------------------------------------------
	logic  p_done;
	logic  p_long;
	word_t p_set;
	word_t p_ven;
	word_t p_csm;

	cmd_frame_parser u_parser (
		.core_clk_in     (core_clk_in),
		.rst_in          (rst_in),
		.rx_valid_in     (rx_valid_in),
		.rx_byte_in      (rx_byte_in),
		.rx_last_in      (rx_last_in),
		.done_out        (p_done),
		.long_enough_out (p_long),
		.settings_out    (p_set),
		.vendor_out      (p_ven),
		.csum_out        (p_csm)
	);

	// ------------------------------------------------------------------
	// settings decode
	// ------------------------------------------------------------------
	speed_t  req_speed;
	duplex_t req_duplex;
	logic    req_autoneg;
	logic    speed_one;
	logic    duplex_one;
	logic    forced_bad;

	// reserved bits 5-7 and 13-31 are never looked at
	assign req_autoneg = set_ff[`BIT_AUTONEG];
	assign req_speed   = set_ff[`SPEED_MSB:`SPEED_LSB];
	assign req_duplex  = {set_ff[`BIT_FULL_DUPLEX], set_ff[`BIT_HALF_DUPLEX]};

	// exactly one bit set and that bit supported
	assign speed_one  = (req_speed != `RST_SPEED)
		&& ((req_speed & (req_speed - 4'h1)) == `RST_SPEED)
		&& ((req_speed & ~speed_supported_in) == `RST_SPEED);
	assign duplex_one = (req_duplex != `RST_DUPLEX)
		&& (req_duplex != ~`RST_DUPLEX)
		&& ((req_duplex & ~duplex_supported_in) == `RST_DUPLEX);

	// only forced mode is checked; autoneg takes any mix of candidates
	assign forced_bad = !req_autoneg && (!speed_one || !duplex_one);

	// ------------------------------------------------------------------
	// handler sequence and captured command
	// ------------------------------------------------------------------
	hstate_t     st_ff, nxt_st;
	logic [7:0]  code_ff, nxt_code;
	word_t       set_ff, nxt_set;
	word_t       ven_ff, nxt_ven;
	logic [15:0] rcode_ff, nxt_rcode;
	logic [15:0] rreas_ff, nxt_rreas;
	logic        start_ff, nxt_start;
	logic        drop_ff, nxt_drop;
	logic        rsp_busy;

	// short set link frames and codes other than set link and AEN enable are left to other handlers
	always_comb begin
		nxt_st    = st_ff;
		nxt_code  = code_ff;
		nxt_set   = set_ff;
		nxt_ven   = ven_ff;
		nxt_rcode = rcode_ff;
		nxt_rreas = rreas_ff;
		nxt_start = 1'b0;
		nxt_drop  = 1'b0;
		case (st_ff)
			ST_IDLE: begin
				if (p_done && p_long && cmd_code_in == `CMD_SET_LINK) begin
					nxt_code = cmd_code_in;
					nxt_set  = p_set;
					nxt_ven  = p_ven;
					nxt_st   = ST_CHECK;
				end else if (p_done && cmd_code_in == `CMD_AEN_ENABLE) begin
					nxt_code  = cmd_code_in;
					nxt_rcode = `RSP_CODE_DONE;
					nxt_rreas = `REASON_NONE;
					nxt_st    = ST_RESPOND;
				end
			end
			ST_CHECK: begin
				if (forced_bad) begin
					nxt_rcode = `RSP_CODE_FAILED;
					nxt_rreas = `REASON_BAD_PARAM;
					nxt_st    = ST_RESPOND;
				end else begin
					nxt_rcode = `RSP_CODE_DONE;
					nxt_rreas = `REASON_NONE;
					nxt_st    = ST_APPLY;
				end
			end
			ST_APPLY: begin
				// hand off to the link and answer at once
				nxt_st = ST_RESPOND;
			end
			ST_RESPOND: begin
				if (!rsp_busy) begin
					nxt_start = 1'b1;
					nxt_st    = ST_IDLE;
				end
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
		// a frame finishing while one is in hand is lost and flagged
		if (p_done && st_ff != ST_IDLE)
			nxt_drop = 1'b1;
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			st_ff    <= ST_IDLE;
			code_ff  <= `RST_BYTE;
			set_ff   <= `RST_WORD;
			ven_ff   <= `RST_WORD;
			rcode_ff <= `RSP_CODE_DONE;
			rreas_ff <= `REASON_NONE;
			start_ff <= 1'b0;
			drop_ff  <= 1'b0;
		end else begin
			st_ff    <= nxt_st;
			code_ff  <= nxt_code;
			set_ff   <= nxt_set;
			ven_ff   <= nxt_ven;
			rcode_ff <= nxt_rcode;
			rreas_ff <= nxt_rreas;
			start_ff <= nxt_start;
			drop_ff  <= nxt_drop;
		end
	end

	// ------------------------------------------------------------------
	// link configuration outputs
	// ------------------------------------------------------------------
	logic    apply_ff, nxt_apply;
	logic    an_ff, nxt_an;
	speed_t  spd_ff, nxt_spd;
	duplex_t dup_ff, nxt_dup;
	logic    psym_ff, nxt_psym;
	logic    pasym_ff, nxt_pasym;
	logic    vapp_ff, nxt_vapp;
	word_t   vword_ff, nxt_vword;

	// settings are held until the next accepted command; apply is a pulse
	always_comb begin
		nxt_apply = 1'b0;
		nxt_an    = an_ff;
		nxt_spd   = spd_ff;
		nxt_dup   = dup_ff;
		nxt_psym  = psym_ff;
		nxt_pasym = pasym_ff;
		nxt_vapp  = 1'b0;
		nxt_vword = vword_ff;
		if (st_ff == ST_APPLY) begin
			nxt_apply = 1'b1;
			nxt_an    = req_autoneg;
			// autoneg advertises every supported candidate asked for
			nxt_spd   = req_autoneg ? (req_speed & speed_supported_in) : req_speed;
			nxt_dup   = req_autoneg ? (req_duplex & duplex_supported_in) : req_duplex;
			nxt_psym  = !set_ff[`BIT_PAUSE_SYM_OFF];
			nxt_pasym = set_ff[`BIT_PAUSE_ASYM];
			if (set_ff[`BIT_VENDOR_VALID]) begin
				nxt_vapp  = 1'b1;
				nxt_vword = ven_ff; // untouched while bit 12 is clear
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			apply_ff <= 1'b0;
			an_ff    <= 1'b0;
			spd_ff   <= `RST_SPEED;
			dup_ff   <= `RST_DUPLEX;
			psym_ff  <= 1'b0;
			pasym_ff <= 1'b0;
			vapp_ff  <= 1'b0;
			vword_ff <= `RST_WORD;
		end else begin
			apply_ff <= nxt_apply;
			an_ff    <= nxt_an;
			spd_ff   <= nxt_spd;
			dup_ff   <= nxt_dup;
			psym_ff  <= nxt_psym;
			pasym_ff <= nxt_pasym;
			vapp_ff  <= nxt_vapp;
			vword_ff <= nxt_vword;
		end
	end

	// ------------------------------------------------------------------
	// response frame
	// ------------------------------------------------------------------
	rsp_frame_builder u_rsp (
		.core_clk_in  (core_clk_in),
		.rst_in       (rst_in),
		.start_in     (start_ff),
		.code_in      (rcode_ff),
		.reason_in    (rreas_ff),
		.csum_in      (rsp_csum_in),
		.tx_ready_in  (tx_ready_in),
		.tx_valid_out (tx_valid_out),
		.tx_byte_out  (tx_byte_out),
		.tx_idx_out   (tx_idx_out),
		.tx_last_out  (tx_last_out),
		.busy_out     (rsp_busy)
	);

	// ------------------------------------------------------------------
	// status
	// ------------------------------------------------------------------
	logic busy_ff, nxt_busy;

	// busy also covers the start pulse cycle but drops for the one cycle after it, before rsp_busy shows
	always_comb begin
		nxt_busy = (nxt_st != ST_IDLE) || nxt_start || rsp_busy;
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			busy_ff <= 1'b0;
		end else begin
			busy_ff <= nxt_busy;
		end
	end

	assign link_apply_out      = apply_ff;
	assign link_autoneg_out    = an_ff;
	assign link_speed_out      = spd_ff;
	assign link_duplex_out     = dup_ff;
	assign link_pause_sym_out  = psym_ff;
	assign link_pause_asym_out = pasym_ff;
	assign vendor_apply_out    = vapp_ff;
	assign vendor_word_out     = vword_ff;
	assign busy_out            = busy_ff;
	assign cmd_dropped_out     = drop_ff;
	assign last_code_out       = rcode_ff;
	assign last_reason_out     = rreas_ff;
endmodule : link_config_command_handler
`default_nettype wire

/* File: link_cfg_map.svh */
// link_cfg_map.svh: byte offsets, bit positions, codes and reset values
// of the link configuration command handler.
// Assumes it is included by bare name from the package; the modules use its macros without including it.
`ifndef LINK_CFG_MAP_SVH
`define LINK_CFG_MAP_SVH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define CMD_AEN_ENABLE       8'h08
`define CMD_SET_LINK         8'h09

// ----------------------------------------------------------------------
// command frame byte positions
// ----------------------------------------------------------------------
`define IDX_SETTINGS_FIRST   6'h10
`define IDX_SETTINGS_LAST    6'h13
`define IDX_VENDOR_FIRST     6'h14
`define IDX_VENDOR_LAST      6'h17
`define IDX_CSUM_FIRST       6'h18
`define IDX_CSUM_LAST        6'h1B
`define IDX_MAX              6'h3F

// ----------------------------------------------------------------------
// response frame byte positions
// ----------------------------------------------------------------------
`define RSP_IDX_FIRST        6'h10
`define RSP_IDX_CSUM_FIRST   6'h14
`define RSP_IDX_PAD_FIRST    6'h18
`define RSP_IDX_LAST         6'h2D
`define RSP_WORD_BYTES       8
`define PAD_BYTE             8'h00

// ----------------------------------------------------------------------
// link settings word fields
// ----------------------------------------------------------------------
`define BIT_AUTONEG          0
`define SPEED_LSB            1
`define SPEED_MSB            4
`define BIT_HALF_DUPLEX      8
`define BIT_FULL_DUPLEX      9
`define BIT_PAUSE_SYM_OFF    10
`define BIT_PAUSE_ASYM       11
`define BIT_VENDOR_VALID     12

// ----------------------------------------------------------------------
// response and reason codes
// ----------------------------------------------------------------------
`define RSP_CODE_DONE        16'h0000
`define RSP_CODE_FAILED      16'h0001
`define REASON_NONE          16'h0000
`define REASON_BAD_PARAM     16'h0002

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_SPEED            4'h0
`define RST_DUPLEX           2'h0
`define RST_WORD             32'h0000_0000
`define RST_BYTE             8'h00
`define RST_IDX              6'h00

`endif

/* File: link_cfg_pkg.sv */
// link_cfg_pkg.sv: types shared by the link configuration handler files.
// Assumes link_cfg_map.svh is on the include path.
`default_nettype none
package link_cfg_pkg;
	`include "link_cfg_map.svh"

	// handler sequence, gray coded along idle, check, apply, respond
	typedef enum logic [1:0] {
		ST_IDLE    = 2'h0,
		ST_CHECK   = 2'h1,
		ST_APPLY   = 2'h3,
		ST_RESPOND = 2'h2
	} hstate_t;

	typedef logic [3:0]  speed_t;
	typedef logic [1:0]  duplex_t;
	typedef logic [5:0]  bidx_t;
	typedef logic [31:0] word_t;
endpackage : link_cfg_pkg
`default_nettype wire

/* File: cmd_frame_parser.sv */
// cmd_frame_parser.sv: pulls the settings, vendor and checksum words out of
// an incoming command frame byte stream.
// Assumes one byte per valid cycle, first byte is byte 0 of the frame.
`default_nettype none
module cmd_frame_parser
	import link_cfg_pkg::*;
(
	// clock and reset
	input  wire logic                core_clk_in,
	input  wire logic                rst_in,
	// frame byte stream
	input  wire logic                rx_valid_in,
	input  wire logic [7:0]          rx_byte_in,
	input  wire logic                rx_last_in,
	// extracted fields
	output logic                     done_out,
	output logic                     long_enough_out,
	output link_cfg_pkg::word_t      settings_out,
	output link_cfg_pkg::word_t      vendor_out,
	output link_cfg_pkg::word_t      csum_out
);
	// ------------------------------------------------------------------
	// byte position and field capture
	// ------------------------------------------------------------------
	bidx_t idx_ff, nxt_idx;
	logic  done_ff, nxt_done;
	logic  long_ff, nxt_long;
	word_t set_ff, nxt_set;
	word_t ven_ff, nxt_ven;
	word_t csm_ff, nxt_csm;

	// fields are big endian; bytes past the checksum are pad and dropped
	always_comb begin
		nxt_idx  = idx_ff;
		nxt_done = 1'b0;
		nxt_long = long_ff;
		nxt_set  = set_ff;
		nxt_ven  = ven_ff;
		nxt_csm  = csm_ff;
		if (rx_valid_in) begin
			if (idx_ff >= `IDX_SETTINGS_FIRST && idx_ff <= `IDX_SETTINGS_LAST)
				nxt_set = {set_ff[23:0], rx_byte_in};
			if (idx_ff >= `IDX_VENDOR_FIRST && idx_ff <= `IDX_VENDOR_LAST)
				nxt_ven = {ven_ff[23:0], rx_byte_in};
			if (idx_ff >= `IDX_CSUM_FIRST && idx_ff <= `IDX_CSUM_LAST)
				nxt_csm = {csm_ff[23:0], rx_byte_in};
			if (idx_ff != `IDX_MAX)
				nxt_idx = idx_ff + 6'h01; // saturates so long pad cannot wrap
			if (rx_last_in) begin
				nxt_done = 1'b1;
				nxt_long = (idx_ff >= `IDX_CSUM_LAST);
				nxt_idx  = `RST_IDX;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			idx_ff  <= `RST_IDX;
			done_ff <= 1'b0;
			long_ff <= 1'b0;
			set_ff  <= `RST_WORD;
			ven_ff  <= `RST_WORD;
			csm_ff  <= `RST_WORD;
		end else begin
			idx_ff  <= nxt_idx;
			done_ff <= nxt_done;
			long_ff <= nxt_long;
			set_ff  <= nxt_set;
			ven_ff  <= nxt_ven;
			csm_ff  <= nxt_csm;
		end
	end

	assign done_out        = done_ff;
	assign long_enough_out = long_ff;
	assign settings_out    = set_ff;
	assign vendor_out      = ven_ff;
	assign csum_out        = csm_ff;
endmodule : cmd_frame_parser
`default_nettype wire

/* File: rsp_frame_builder.sv */
// rsp_frame_builder.sv: emits bytes 16 to 45 of a response frame: code,
// reason, checksum, then zero pad.
// Assumes the header bytes are sent by the surrounding channel logic.
`default_nettype none
module rsp_frame_builder
	import link_cfg_pkg::*;
(
	// clock and reset
	input  wire logic                core_clk_in,
	input  wire logic                rst_in,
	// load
	input  wire logic                start_in,
	input  wire logic [15:0]         code_in,
	input  wire logic [15:0]         reason_in,
	input  link_cfg_pkg::word_t      csum_in,
	// byte stream
	input  wire logic                tx_ready_in,
	output logic                     tx_valid_out,
	output logic [7:0]               tx_byte_out,
	output link_cfg_pkg::bidx_t      tx_idx_out,
	output logic                     tx_last_out,
	output logic                     busy_out
);
	// ------------------------------------------------------------------
	// response word bytes and output stage
	// ------------------------------------------------------------------
	logic [7:0] word_bytes [`RSP_WORD_BYTES];
	logic [63:0] word_ff, nxt_word;
	bidx_t      idx_ff, nxt_idx;
	logic       val_ff, nxt_val;
	logic [7:0] byte_ff, nxt_byte;
	logic       last_ff, nxt_last;

	// one byte lane per entry of the code, reason and checksum word
	genvar k;
	generate
		for (k = 0; k < `RSP_WORD_BYTES; k++) begin : g_lane
			assign word_bytes[k] = nxt_word[(`RSP_WORD_BYTES - 1 - k) * 8 +: 8];
		end
	endgenerate

	// output holds until taken; pad bytes read as zero
	always_comb begin
		nxt_word = word_ff;
		nxt_idx  = idx_ff;
		nxt_val  = val_ff;
		nxt_byte = byte_ff;
		nxt_last = last_ff;
		if (!val_ff && start_in) begin
			nxt_word = {code_in, reason_in, csum_in};
			nxt_idx  = `RSP_IDX_FIRST;
			nxt_val  = 1'b1;
		end else if (val_ff && tx_ready_in) begin
			if (last_ff) begin
				nxt_val = 1'b0;
			end else begin
				nxt_idx = idx_ff + 6'h01;
			end
		end
		nxt_last = nxt_val && (nxt_idx == `RSP_IDX_LAST);
		if (nxt_idx < `RSP_IDX_PAD_FIRST)
			nxt_byte = word_bytes[3'(nxt_idx - `RSP_IDX_FIRST)];
		else
			nxt_byte = `PAD_BYTE;
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			word_ff <= {`RST_WORD, `RST_WORD};
			idx_ff  <= `RST_IDX;
			val_ff  <= 1'b0;
			byte_ff <= `RST_BYTE;
			last_ff <= 1'b0;
		end else begin
			word_ff <= nxt_word;
			idx_ff  <= nxt_idx;
			val_ff  <= nxt_val;
			byte_ff <= nxt_byte;
			last_ff <= nxt_last;
		end
	end

	assign tx_valid_out = val_ff;
	assign tx_byte_out  = byte_ff;
	assign tx_idx_out   = idx_ff;
	assign tx_last_out  = last_ff;
	assign busy_out     = val_ff;
endmodule : rsp_frame_builder
`default_nettype wire

/* File: link_cfg_sva.sv */
// link_cfg_sva.sv: port-level checks of the link configuration handler.
// Assumes the bench binds it onto the handler, one clock, sync reset.
`default_nettype none
module link_cfg_sva
	import link_cfg_pkg::*;
(
	// clock and reset
	input wire logic                 core_clk_in,
	input wire logic                 rst_in,
	// response stream
	input wire logic                 tx_ready_in,
	input wire logic                 tx_valid_out,
	input wire logic [7:0]           tx_byte_out,
	input wire link_cfg_pkg::bidx_t  tx_idx_out,
	input wire logic                 tx_last_out,
	// link request and status
	input wire logic                 link_apply_out,
	input wire logic                 link_autoneg_out,
	input wire link_cfg_pkg::speed_t link_speed_out,
	input wire link_cfg_pkg::duplex_t link_duplex_out,
	input wire logic                 vendor_apply_out,
	input wire logic [15:0]          last_code_out,
	input wire logic [15:0]          last_reason_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	chk_apply_pulse: assert property (link_apply_out |=> !link_apply_out)
		else $error("link apply longer than one cycle");
	chk_vendor_pair: assert property (vendor_apply_out |-> link_apply_out)
		else $error("vendor apply without link apply");
	chk_rsp_prompt: assert property (link_apply_out |-> ##[1:4] tx_valid_out)
		else $error("response late after link apply");
	chk_forced_exact: assert property (link_apply_out && !link_autoneg_out
		|-> $onehot(link_speed_out) && $onehot(link_duplex_out))
		else $error("forced link not one speed and one duplex");
	chk_fail_reason: assert property ((last_code_out == 16'h0001)
		== (last_reason_out == 16'h0002))
		else $error("failed code and reason disagree");
	chk_last_index: assert property (tx_last_out |-> tx_valid_out && tx_idx_out == 6'h2D)
		else $error("last byte not at index 45");
	chk_pad_zero: assert property (tx_valid_out && tx_idx_out >= 6'h18 |-> tx_byte_out == 8'h00)
		else $error("pad byte not zero");
	chk_stall_hold: assert property (tx_valid_out && !tx_ready_in
		|=> tx_valid_out && $stable(tx_byte_out) && $stable(tx_idx_out))
		else $error("response byte moved while stalled");
	chk_index_step: assert property (tx_valid_out && tx_ready_in && !tx_last_out
		|=> tx_idx_out == $past(tx_idx_out) + 6'h01)
		else $error("response index did not step by one");
	// main scenarios reached
	cov_autoneg: cover property (link_apply_out && link_autoneg_out);
	cov_failed: cover property (last_code_out == 16'h0001);
	cov_last: cover property (tx_last_out && tx_ready_in);
endmodule : link_cfg_sva
`default_nettype wire

/* File: mc_model.sv */
// mc_model.sv: management controller model, sends command frames and
// takes response bytes. Assumes the bench calls send_frame after an edge.
`default_nettype none
module mc_model
	import link_cfg_pkg::*;
(
	// clock and pacing
	input  wire logic                core_clk_in,
	input  wire logic                slow_in,
	// command stream
	output logic                     rx_valid_out,
	output logic [7:0]               rx_byte_out,
	output logic                     rx_last_out,
	// response stream
	output logic                     tx_ready_out,
	input  wire logic                tx_valid_in,
	input  wire logic [7:0]          tx_byte_in,
	input  wire link_cfg_pkg::bidx_t tx_idx_in,
	input  wire logic                tx_last_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] rsp [64];
	logic       done;
	initial begin
		rx_valid_out = 1'b0;
		rx_byte_out = 8'h00;
		rx_last_out = 1'b0;
		tx_ready_out = 1'b1;
		done = 1'b0;
	end
	// slow mode stalls every other cycle to exercise the hold path
	always @(posedge core_clk_in) begin
		if (tx_valid_in && tx_ready_out) begin
			rsp[tx_idx_in] <= tx_byte_in;
			if (tx_last_in)
				done <= 1'b1;
		end
		tx_ready_out <= #1 slow_in ? ~tx_ready_out : 1'b1;
	end
	// frame bytes big endian; header, checksum and pad carry filler
	task automatic send_frame(input int n, input word_t s, input word_t v);
		logic [7:0] b;
		done = 1'b0;
		for (int i = 0; i < n; i++) begin
			b = 8'hA5;
			if (i >= 16 && i < 20) b = s[8*(19-i) +: 8];
			if (i >= 20 && i < 24) b = v[8*(23-i) +: 8];
			rx_valid_out = 1'b1;
			rx_byte_out = b;
			rx_last_out = (i == n - 1);
			@(posedge core_clk_in);
			#1;
		end
		rx_valid_out = 1'b0;
		rx_last_out = 1'b0;
		rx_byte_out = ~rx_byte_out;
	endtask : send_frame
endmodule : mc_model
`default_nettype wire

/* File: link_config_command_handler_tb_top.sv */
// link_config_command_handler_tb_top.sv: self-checking bench of the handler.
// Assumes mc_model and link_cfg_sva are compiled alongside.
`default_nettype none
module link_config_command_handler_tb_top;
	import link_cfg_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk_in, rst_in, rx_valid_in, rx_last_in, tx_ready_in, slow;
	logic [7:0] rx_byte_in, cmd_code_in, tx_byte_out;
	logic tx_valid_out, tx_last_out, link_apply_out, link_autoneg_out, busy_out;
	logic link_pause_sym_out, link_pause_asym_out, vendor_apply_out, cmd_dropped_out;
	speed_t speed_supported_in, link_speed_out;
	duplex_t duplex_supported_in, link_duplex_out;
	word_t rsp_csum_in, vendor_word_out;
	bidx_t tx_idx_out;
	logic [15:0] last_code_out, last_reason_out;
	int fails, n_checks, n_apply, n_vend;
	link_config_command_handler DUT (.core_clk_in, .rst_in, .rx_valid_in, .rx_byte_in,
		.rx_last_in, .cmd_code_in, .speed_supported_in, .duplex_supported_in,
		.rsp_csum_in, .tx_ready_in, .tx_valid_out, .tx_byte_out, .tx_idx_out, .tx_last_out,
		.link_apply_out, .link_autoneg_out, .link_speed_out, .link_duplex_out,
		.link_pause_sym_out, .link_pause_asym_out, .vendor_apply_out, .vendor_word_out,
		.busy_out, .cmd_dropped_out(), .last_code_out, .last_reason_out);
	mc_model mc (.core_clk_in, .slow_in(slow), .rx_valid_out(rx_valid_in),
		.rx_byte_out(rx_byte_in), .rx_last_out(rx_last_in), .tx_ready_out(tx_ready_in),
		.tx_valid_in(tx_valid_out), .tx_byte_in(tx_byte_out), .tx_idx_in(tx_idx_out),
		.tx_last_in(tx_last_out));
	// count link requests so refused frames can be seen to change nothing
	always @(posedge core_clk_in) begin
		n_apply += int'(link_apply_out === 1'b1);
		n_vend += int'(vendor_apply_out === 1'b1);
	end
	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end
	task automatic check(input string what, input logic [31:0] exp, got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic give_verdict;
		if (fails == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	// send one frame and wait, bounded, for the whole response
	task automatic run(input logic [7:0] c, input int n, input word_t s, v, input logic sl);
		cmd_code_in = c;
		slow = sl;
		rsp_csum_in += 32'h1111_1111;
		n_apply = 0;
		n_vend = 0;
		mc.send_frame(n, s, v);
		for (int i = 0; i < 150 && mc.done !== 1'b1; i++) @(posedge core_clk_in);
		#1;
	endtask : run
	task automatic rsp_check(input logic [15:0] c, r);
		check("done", 1, mc.done);
		check("code", c, {mc.rsp[16], mc.rsp[17], mc.rsp[18], mc.rsp[19]} >> 16);
		check("reason", r, {mc.rsp[18], mc.rsp[19]});
		check("csum", rsp_csum_in, {mc.rsp[20], mc.rsp[21], mc.rsp[22], mc.rsp[23]});
		for (int i = 24; i < 46; i++) check("pad", 0, mc.rsp[i]);
		check("last code", {c, r}, {last_code_out, last_reason_out});
	endtask : rsp_check
	task automatic s_forced_ok;
		run(8'h09, 46, 32'h0000_1A28, 32'hCAFE_F00D, 1'b0);
		rsp_check(16'h0000, 16'h0000);
		check("applies", 2, n_apply + n_vend);
		check("link", {1'b0, 4'h4, 2'h2, 2'b11}, {link_autoneg_out, link_speed_out,
			link_duplex_out, link_pause_sym_out, link_pause_asym_out});
		check("vendor", 32'hCAFE_F00D, vendor_word_out);
	endtask : s_forced_ok
	task automatic s_autoneg;
		run(8'h09, 46, 32'h0000_071F, 32'h1234_5678, 1'b1);
		rsp_check(16'h0000, 16'h0000);
		check("applies", 1, n_apply + n_vend);
		check("link", {1'b1, 4'h7, 2'h3, 2'b00}, {link_autoneg_out, link_speed_out,
			link_duplex_out, link_pause_sym_out, link_pause_asym_out});
		check("vendor", 32'hCAFE_F00D, vendor_word_out);
	endtask : s_autoneg
	task automatic s_forced_bad;
		word_t bad [4] = '{32'h0206, 32'h0210, 32'h0302, 32'h0002};
		foreach (bad[i]) begin
			run(8'h09, 46, bad[i], 0, i[0]);
			rsp_check(16'h0001, 16'h0002);
			check("applies", 0, n_apply);
			check("speed", 4'h7, link_speed_out);
		end
	endtask : s_forced_bad
	task automatic s_short_and_aen;
		run(8'h09, 27, 32'h0000_0204, 0, 1'b0);
		check("short ignored", 0, {mc.done, 8'(n_apply)});
		run(8'h08, 46, 0, 0, 1'b1);
		rsp_check(16'h0000, 16'h0000);
		check("aen applies", 0, n_apply);
	endtask : s_short_and_aen
	initial begin
		fails = 0;
		n_checks = 0;
		rst_in = 1'b1;
		slow = 1'b0;
		cmd_code_in = 8'h00;
		speed_supported_in = 4'h7;
		duplex_supported_in = 2'h3;
		rsp_csum_in = 32'h0BAD_F00D;
		repeat (6) @(posedge core_clk_in);
		#1 rst_in = 1'b0;
		s_forced_ok();
		s_autoneg();
		s_forced_bad();
		s_short_and_aen();
		give_verdict();
	end
	// about 900 cycles expected; cut off well beyond
	initial begin
		#80000;
		fails++;
		give_verdict();
	end
endmodule : link_config_command_handler_tb_top
bind link_config_command_handler link_cfg_sva u_sva (.core_clk_in(core_clk_in),
	.rst_in(rst_in), .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out),
	.tx_byte_out(tx_byte_out), .tx_idx_out(tx_idx_out), .tx_last_out(tx_last_out),
	.link_apply_out(link_apply_out), .link_autoneg_out(link_autoneg_out),
	.link_speed_out(link_speed_out), .link_duplex_out(link_duplex_out),
	.vendor_apply_out(vendor_apply_out), .last_code_out(last_code_out),
	.last_reason_out(last_reason_out));
`default_nettype wire
